// *** bench/rfsr_fault_status_props.sv ***
// Port checks of the fault status bank
`timescale 1ns/1ps
module rfsr_fault_status_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reg_enabled,
  input wire logic latched_off,
  input wire logic [1:0] ilim_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus steps
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_ctrl_wr;
    pready && pwrite && paddr == 12'h000 && pstrb[0];
  endsequence
  // Properties
  property p_wait;
    s_setup |-> !pready ##1 pready;
  endproperty
  property p_one;
    pready |=> !pready;
  endproperty
  property p_err;
    pready && paddr > 12'h014 |-> pslverr;
  endproperty
  property p_rd0;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_upper;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  property p_off;
    latched_off |-> !reg_enabled;
  endproperty
  property p_ilim;
    s_ctrl_wr |-> ##2 ilim_sel == $past(pwdata[5:4], 2);
  endproperty
  property p_enoff;
    s_ctrl_wr ##0 pwdata[1:0] == 2'b00 |-> ##[1:3] !reg_enabled;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state");
  a_one: assert property (p_one) else $error("pready width");
  a_err: assert property (p_err) else $error("unmapped ok");
  a_rd0: assert property (p_rd0) else $error("idle rdata");
  a_upper: assert property (p_upper) else $error("upper bits");
  a_off: assert property (p_off) else $error("on while latched");
  a_ilim: assert property (p_ilim) else $error("ilim_sel");
  a_enoff: assert property (p_enoff) else $error("still enabled");
endmodule

// *** bench/rfsr_host.sv ***
// Bus host model standing in for the polling bridge
`timescale 1ns/1ps
module rfsr_host #(
  parameter int POLL_CYCLES = 64
) (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic aux_trigger_out
);
  // Idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, aux_trigger_out} = '0;
  end
  logic [7:0] status_copy = 8'h00;
  // One transfer, held until pready, trigger marks a user access only
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e, input logic u = 1'b1);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'hf};
    aux_trigger_out <= u;
    @(posedge pclk);
    penable <= 1'b1;
    aux_trigger_out <= 1'b0;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Periodic refresh of the status copy, interval cut short to keep runs brief
  task poll();
    logic [31:0] r;
    logic e;
    repeat (POLL_CYCLES) @(posedge pclk);
    xfer(1'b0, 12'h00c, 32'h0, r, e, 1'b0);
    status_copy = r[7:0];
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench of the fault status bank
`timescale 1ns/1ps
module testbench;
  import rfsr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, enable_pin, reg_enabled, latched_off, irq, aux, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [1:0] ilim_sel;
  rfsr_mon_t mon;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_aux = 0;
  int aux_base;
  // Clock of 4 ns
  always #2 pclk = ~pclk;
  // Count of trigger pulses from the host
  always @(posedge pclk) begin
    if (aux) begin
      n_aux++;
    end
  end
  rfsr_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .aux_trigger_out(aux));
  rfsr_fault_status uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .enable_pin, .mon, .reg_enabled, .latched_off, .ilim_sel, .irq);
  // Verdict and end of run
  task summarize();
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, q, er);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 32'h0, q, er);
    chk("rdata", {24'h0, e}, q);
    chk("slverr", 32'h0, {31'h0, er});
  endtask
  task pwr_cycle();
    @(posedge pclk);
    presetn <= 1'b0;
    wt(3);
    presetn <= 1'b1;
  endtask
  // Shutdown or hiccup pulses from the monitor
  task pulses(input logic th, input int n);
    repeat (n) begin
      if (th) mon.temp_degc <= 9'd165;
      else mon.hiccup_evt <= 1'b1;
      wt(6);
      mon.temp_degc <= 9'd25;
      mon.hiccup_evt <= 1'b0;
      wt(6);
    end
  endtask
  task latch_run(input logic th, input logic [7:0] c2);
    pwr_cycle();
    wr(12'h004, c2);
    wr(12'h000, 8'h21);
    pulses(th, 3);
    chk("latch early", 32'h0, {31'h0, latched_off});
    pulses(th, 1);
    chk("latch", 32'h1, {31'h0, latched_off});
  endtask
  // Main sequence
  initial begin
    mon = '0;
    mon.temp_degc = 9'd25;
    enable_pin = 1'b0;
    pwr_cycle();
    rd(12'h000, 8'h00);
    rd(12'h014, 8'h00);
    host.xfer(1'b0, 12'h018, 32'h0, q, er);
    chk("unmapped", 32'h1, {31'h0, er});
    wr(12'h008, 8'h5a);
    rd(12'h008, 8'h5a);
    wr(12'h000, 8'h21);
    wt(6);
    rd(12'h000, 8'h21);
    chk("ilim_sel", 32'h2, {30'h0, ilim_sel});
    chk("enabled", 32'h1, {31'h0, reg_enabled});
    mon.softstart_ok <= 1'b1;
    mon.vout_pct <= 8'd90;
    wt(8);
    rd(12'h00c, 8'h50);
    mon.vout_pct <= 8'd91;
    mon.temp_degc <= 9'd119;
    wt(8);
    rd(12'h00c, 8'hd1);
    mon.temp_degc <= 9'd118;
    mon.ilim_hit <= 1'b1;
    mon.boot_fail <= 1'b1;
    wt(8);
    mon.ilim_hit <= 1'b0;
    mon.boot_fail <= 1'b0;
    wt(8);
    rd(12'h00c, 8'h79);
    rd(12'h00c, 8'h79);
    aux_base = n_aux;
    host.poll();
    chk("poll", 32'h79, {24'h0, host.status_copy});
    chk("aux poll", aux_base, n_aux);
    rd(12'h00c, 8'h79);
    chk("aux user", aux_base + 1, n_aux);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(12'h014, 8'h08);
    wt(3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h010, 8'hff);
    wt(3);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(12'h010, 8'h00);
    mon.softstart_ok <= 1'b0;
    wr(12'h000, 8'h20);
    wt(8);
    rd(12'h00c, 8'h00);
    wr(12'h000, 8'h02);
    enable_pin <= 1'b1;
    wt(6);
    chk("pin enable", 32'h1, {31'h0, reg_enabled});
    enable_pin <= 1'b0;
    wr(12'h000, 8'h21);
    pulses(1'b1, 1);
    chk("latch now", 32'h1, {31'h0, latched_off});
    rd(12'h00c, 8'h47);
    mon.vout_pct <= 8'd0;
    latch_run(1'b1, 8'h20);
    latch_run(1'b0, 8'h00);
    wr(12'h000, 8'h20);
    wt(3);
    chk("latch clear", 32'h0, {31'h0, latched_off});
    summarize();
  end
  // Watchdog
  initial begin
    #40000;
    n_mismatch++;
    summarize();
  end
endmodule
bind rfsr_fault_status rfsr_fault_status_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .reg_enabled, .latched_off,
  .ilim_sel);

// *** src/rfsr_fault_status.sv ***
// Fault and status register bank of a configurable buck regulator, APB slave
`timescale 1ns/1ps
`include "rfsr_regs.svh"
module rfsr_fault_status
  import rfsr_pkg::*;
#(
  parameter logic [7:0] LATCH_MASK = 8'h3e,
  parameter int HICCUP_LIMIT = `RFSR_HICCUP_LIMIT,
  parameter int TSD_CYCLE_LIMIT = `RFSR_TSD_CYCLE_LIMIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_pin,
  input wire rfsr_mon_t mon,
  output logic reg_enabled,
  output logic latched_off,
  output logic [1:0] ilim_sel,
  output logic irq
);

  // ------------------------------------------------------------
  // Pin and monitor synchronisers
  // ------------------------------------------------------------
  logic en_pin_s1_reg;
  logic en_pin_s2_reg;
  rfsr_mon_t mon_s1_reg;
  rfsr_mon_t mon_s2_reg;
  rfsr_mon_t mon_s3_reg;
  rfsr_mon_t mon_q_reg;

  // Two flops before any logic looks at outside inputs
  // Reset values match idle inputs, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_pin_s1_reg <= 1'b0;
      en_pin_s2_reg <= 1'b0;
      mon_s1_reg <= '0;
      mon_s2_reg <= '0;
    end else begin
      en_pin_s1_reg <= enable_pin;
      en_pin_s2_reg <= en_pin_s1_reg;
      mon_s1_reg <= mon;
      mon_s2_reg <= mon_s1_reg;
    end
  end

  // Monitor word taken only when two samples agree; a word caught mid-change
  // may mix old and new bits, so one extra cycle of latency buys a clean word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_s3_reg <= '0;
      mon_q_reg <= '0;
    end else begin
      mon_s3_reg <= mon_s2_reg;
      if (mon_s2_reg == mon_s3_reg) begin
        mon_q_reg <= mon_s2_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] vout_reg;
  logic [7:0] event_reg;
  logic [7:0] mask_reg;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // Access phase qualifies the transfer; slave answers in its second cycle
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == `RFSR_ADDR_CTRL1) | (paddr == `RFSR_ADDR_CTRL2) |
                   (paddr == `RFSR_ADDR_VOUT) | (paddr == `RFSR_ADDR_STATUS) |
                   (paddr == `RFSR_ADDR_EVENT) | (paddr == `RFSR_ADDR_MASK);

  // Writable control bytes, lane 0 only
  // Unmapped or strobe-less writes change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_reg <= `RFSR_CTRL1_RST;
      ctrl2_reg <= `RFSR_CTRL2_RST;
      vout_reg <= `RFSR_VOUT_RST;
      mask_reg <= `RFSR_MASK_RST;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == `RFSR_ADDR_CTRL1) begin
        ctrl1_reg <= pwdata[7:0];
      end
      if (paddr == `RFSR_ADDR_CTRL2) begin
        ctrl2_reg <= pwdata[7:0];
      end
      if (paddr == `RFSR_ADDR_VOUT) begin
        vout_reg <= pwdata[7:0];
      end
      if (paddr == `RFSR_ADDR_MASK) begin
        mask_reg <= pwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Enable state
  // ------------------------------------------------------------
  logic en_req;
  logic en_state_reg;
  logic en_fall;

  // Pin or register bit selects the on request
  assign en_req = ctrl1_reg[`RFSR_CTRL1_ENSRC_BIT] ? en_pin_s2_reg :
                  ctrl1_reg[`RFSR_CTRL1_ENBIT_BIT];

  // Internal on state, one flop behind the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_state_reg <= 1'b0;
    end else begin
      en_state_reg <= en_req;
    end
  end

  // On to off transition clears sticky flags; the request is read ahead of
  // the flop so the clear lands on the edge where the state drops
  assign en_fall = en_state_reg & ~en_req;

  // ------------------------------------------------------------
  // Fault conditions
  // ------------------------------------------------------------
  logic good_c;
  logic twarn_c;
  logic tsd_c;
  logic tsd_d_reg;
  logic hic_d_reg;
  logic [2:0] hic_cnt_reg;
  logic [2:0] tsd_cnt_reg;
  logic lo_c;
  logic tsd_rise;
  logic hic_rise;

  // Threshold compares on the filtered monitor word
  assign good_c = en_state_reg &
                  ({1'b0, mon_q_reg.vout_pct} >= 9'(`RFSR_GOOD_PCT));
  assign twarn_c = mon_q_reg.temp_degc > 9'(`RFSR_TWARN_DEGC);
  assign tsd_c = mon_q_reg.temp_degc >= 9'(`RFSR_TSD_DEGC);
  // Entries into shutdown and hiccup as one-cycle strobes
  assign tsd_rise = tsd_c & ~tsd_d_reg;
  assign hic_rise = mon_q_reg.hiccup_evt & ~hic_d_reg;

  // Edge history of the fault conditions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsd_d_reg <= 1'b0;
      hic_d_reg <= 1'b0;
    end else begin
      tsd_d_reg <= tsd_c;
      hic_d_reg <= mon_q_reg.hiccup_evt;
    end
  end

  // Consecutive hiccups; a good output breaks the run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hic_cnt_reg <= 3'h0;
    end else if (en_fall || (good_c && !mon_q_reg.hiccup_evt)) begin
      hic_cnt_reg <= 3'h0;
    end else if (hic_rise && hic_cnt_reg != 3'(HICCUP_LIMIT)) begin
      hic_cnt_reg <= hic_cnt_reg + 3'h1;
    end
  end

  // Thermal shutdown cycles counted for the delayed latch policy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsd_cnt_reg <= 3'h0;
    end else if (en_fall) begin
      tsd_cnt_reg <= 3'h0;
    end else if (tsd_rise && tsd_cnt_reg != 3'(TSD_CYCLE_LIMIT)) begin
      tsd_cnt_reg <= tsd_cnt_reg + 3'h1;
    end
  end

  // Latch off on hiccup run or thermal event per policy; held low on the
  // clearing edge, where the counters still show their old count
  assign lo_c = ~en_fall & ((hic_cnt_reg == 3'(HICCUP_LIMIT)) |
                (ctrl2_reg[`RFSR_CTRL2_TLATCH_BIT] ?
                 (tsd_cnt_reg == 3'(TSD_CYCLE_LIMIT)) : tsd_c));

  // ------------------------------------------------------------
  // Status byte
  // ------------------------------------------------------------
  rfsr_status_t cond_v;
  rfsr_status_t status_v;

  // Condition of each status bit in byte order
  always_comb begin
    cond_v.output_good = good_c;
    cond_v.latched_off = lo_c;
    cond_v.thermal_shutdown_flag = tsd_c;
    cond_v.current_limit = mon_q_reg.ilim_hit;
    cond_v.softstart_complete = en_state_reg & mon_q_reg.softstart_ok;
    cond_v.boot_error = mon_q_reg.boot_fail;
    cond_v.reg_enabled = en_state_reg;
    cond_v.temp_warning = twarn_c;
  end

  // Default mask keeps latch off, shutdown, current limit, soft start and
  // boot error sticky; good, enabled and warning follow their condition
  // One cell per bit, class chosen by parameter
  for (genvar i = 0; i < 8; i++) begin : g_bit
    rfsr_status_bit #(
      .LATCHED(LATCH_MASK[i])
    ) u_bit (
      .pclk(pclk),
      .presetn(presetn),
      .cond(cond_v[i]),
      .clear(en_fall),
      .bit_q(status_v[i])
    );
  end

  // ------------------------------------------------------------
  // Interrupt events
  // ------------------------------------------------------------
  logic [7:0] status_d_reg;
  logic [7:0] rise_v;
  logic [7:0] ev_clr;
  logic [7:0] event_next;

  assign rise_v = status_v & ~status_d_reg;
  assign ev_clr = (wr_en && pstrb[0] && paddr == `RFSR_ADDR_EVENT) ? pwdata[7:0] : 8'h00;
  // A bit that rises in the cycle of its write of one keeps its event
  assign event_next = rise_v | (event_reg & ~ev_clr);

  // Rising status bits set sticky events, set beats write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_d_reg <= 8'h00;
      event_reg <= 8'h00;
    end else begin
      status_d_reg <= status_v;
      event_reg <= event_next;
    end
  end

  // Level interrupt from unmasked events, taken from the next event value
  // so it drops on the same edge as the events it reports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_next & mask_reg);
    end
  end

  // ------------------------------------------------------------
  // Core outputs
  // ------------------------------------------------------------
  // Core side copies, registered so every output leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_enabled <= 1'b0;
      latched_off <= 1'b0;
      ilim_sel <= 2'h0;
    end else begin
      reg_enabled <= en_req & ~status_v.latched_off;
      latched_off <= status_v.latched_off;
      ilim_sel <= ctrl1_reg[`RFSR_CTRL1_ILIM_LSB +: 2];
    end
  end

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  logic [7:0] rd_byte;

  // Read mux, status read has no side effect
  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr)
      `RFSR_ADDR_CTRL1: rd_byte = ctrl1_reg;
      `RFSR_ADDR_CTRL2: rd_byte = ctrl2_reg;
      `RFSR_ADDR_VOUT: rd_byte = vout_reg;
      `RFSR_ADDR_STATUS: rd_byte = status_v;
      `RFSR_ADDR_EVENT: rd_byte = event_reg;
      `RFSR_ADDR_MASK: rd_byte = mask_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: pready rises in second access cycle
  // Write lands and read data leaves at the edge where the master sees pready;
  // idle cycles drive zero so no stale read data lingers on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
      prdata <= (rd_en && addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

endmodule

// *** src/rfsr_pkg.sv ***
// Types shared by the fault status bank
package rfsr_pkg;
  // Analog monitor readings taken by the core
  typedef struct packed {
    logic [7:0] vout_pct;
    logic [8:0] temp_degc;
    logic ilim_hit;
    logic softstart_ok;
    logic boot_fail;
    logic hiccup_evt;
  } rfsr_mon_t;
  // Status byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic temp_warning;
    logic reg_enabled;
    logic boot_error;
    logic softstart_complete;
    logic current_limit;
    logic thermal_shutdown_flag;
    logic latched_off;
    logic output_good;
  } rfsr_status_t;
  typedef enum logic [1:0] {
    RFSR_IDLE,
    RFSR_SETUP,
    RFSR_ACCESS
  } rfsr_apb_st_t;
endpackage

// *** src/rfsr_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the fault status bank
`ifndef RFSR_REGS_SVH
`define RFSR_REGS_SVH

// Byte addresses (printed offsets are register indices, address is four times the index)
`define RFSR_IDX_CTRL1 0
`define RFSR_IDX_CTRL2 1
`define RFSR_IDX_VOUT 2
`define RFSR_IDX_STATUS 3
`define RFSR_ADDR_CTRL1 12'h000
`define RFSR_ADDR_CTRL2 12'h004
`define RFSR_ADDR_VOUT 12'h008
`define RFSR_ADDR_STATUS 12'h00c
`define RFSR_ADDR_EVENT 12'h010
`define RFSR_ADDR_MASK 12'h014

// Control field positions
`define RFSR_CTRL1_ENSRC_BIT 1
`define RFSR_CTRL1_ENBIT_BIT 0
`define RFSR_CTRL1_ILIM_LSB 4
`define RFSR_CTRL2_TLATCH_BIT 5

// Status byte field positions
`define RFSR_ST_GOOD 0
`define RFSR_ST_LATCHOFF 1
`define RFSR_ST_TSD 2
`define RFSR_ST_ILIM 3
`define RFSR_ST_SSD 4
`define RFSR_ST_BOOTERR 5
`define RFSR_ST_EN 6
`define RFSR_ST_TWARN 7

// Reset values
`define RFSR_CTRL1_RST 8'h00
`define RFSR_CTRL2_RST 8'h00
`define RFSR_VOUT_RST 8'h00
`define RFSR_MASK_RST 8'h00

// Thresholds
`define RFSR_GOOD_PCT 91
`define RFSR_TWARN_DEGC 118
`define RFSR_TSD_DEGC 165
`define RFSR_HICCUP_LIMIT 4
`define RFSR_TSD_CYCLE_LIMIT 4

`endif

// *** src/rfsr_status_bit.sv ***
// One status bit, either sticky flag or live status
`timescale 1ns/1ps
module rfsr_status_bit #(
  parameter bit LATCHED = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cond,
  input wire logic clear,
  output logic bit_q
);
  // Sticky flag holds until clear, set wins; live bit follows condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 1'b0;
    end else if (LATCHED) begin
      bit_q <= cond | (bit_q & ~clear);
    end else begin
      bit_q <= cond;
    end
  end
endmodule
